/* File: verilog/eim_pkg.sv */
package eim_pkg;

  // ----------------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------------
  localparam int          ADR_W        = 8;
  localparam logic [7:0]  OFS_PIN0     = 8'h00;  // Pin n at OFS_PIN0 + 4*n
  localparam logic [7:0]  OFS_MASK     = 8'h10;
  localparam logic [7:0]  OFS_FLAGS    = 8'h14;
  localparam logic [7:0]  OFS_PINLVL   = 8'h18;
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Pin configuration field layout and reset values
  // ----------------------------------------------------------------------
  localparam int         CFG_W        = 8;
  localparam int         FUNC_HI      = 7;
  localparam int         FUNC_LO      = 3;
  localparam int         DIR_HI       = 1;
  localparam int         DIR_LO       = 0;
  localparam logic [7:0] CFG_RES_MASK = 8'hfb;   // Bit 2 reads zero
  localparam logic [7:0] CFG_RST_PIN0 = 8'h0a;
  localparam logic [7:0] CFG_RST_PINX = 8'ha2;
  localparam logic [1:0] DIR_INPUT    = 2'h1;
  localparam logic [1:0] DIR_OUT_LO   = 2'h2;
  localparam logic [1:0] DIR_OUT_HI   = 2'h3;

  // ----------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------
  localparam int          EVT_W        = 32;
  localparam logic [31:0] EVT_IMPL     = 32'h300f_ffff;
  localparam logic [31:0] MASK_RST     = 32'h0000_0000;
  localparam int          EVT_WAKEUP   = 15;
  localparam int          EVT_READY    = 16;

  // ----------------------------------------------------------------------
  // Output function codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] OF_IRQ      = 5'h00;
  localparam logic [4:0] OF_POR_N    = 5'h01;
  localparam logic [4:0] OF_WUT      = 5'h02;
  localparam logic [4:0] OF_LOWBAT   = 5'h03;
  localparam logic [4:0] OF_TXCLK    = 5'h04;
  localparam logic [4:0] OF_TXSTATE  = 5'h05;
  localparam logic [4:0] OF_AEMPTY   = 5'h06;
  localparam logic [4:0] OF_AFULL    = 5'h07;
  localparam logic [4:0] OF_RXDATA   = 5'h08;
  localparam logic [4:0] OF_RXCLK    = 5'h09;
  localparam logic [4:0] OF_INRX     = 5'h0a;
  localparam logic [4:0] OF_AWAKE    = 5'h0b;
  localparam logic [4:0] OF_STANDBY  = 5'h0c;
  localparam logic [4:0] OF_ANTSW    = 5'h0d;
  localparam logic [4:0] OF_PREAMB   = 5'h0e;
  localparam logic [4:0] OF_SYNC     = 5'h0f;
  localparam logic [4:0] OF_RSSI     = 5'h10;
  localparam logic [4:0] OF_TXRX     = 5'h12;
  localparam logic [4:0] OF_VDD      = 5'h13;
  localparam logic [4:0] OF_GND      = 5'h14;
  localparam logic [4:0] OF_SMPS     = 5'h15;
  localparam logic [4:0] OF_SLEEP    = 5'h16;
  localparam logic [4:0] OF_READY    = 5'h17;
  localparam logic [4:0] OF_LOCK     = 5'h18;
  localparam logic [4:0] OF_WLOCK    = 5'h19;
  localparam logic [4:0] OF_ONOFF    = 5'h1a;
  localparam logic [4:0] OF_WOSC2    = 5'h1b;
  localparam logic [4:0] OF_WSETTLE  = 5'h1c;
  localparam logic [4:0] OF_WCAL     = 5'h1d;
  localparam logic [4:0] OF_SYNTH    = 5'h1e;

  // Input function codes
  localparam logic [4:0] IF_TXCMD    = 5'h00;
  localparam logic [4:0] IF_RXCMD    = 5'h01;
  localparam logic [4:0] IF_TXDATA   = 5'h02;
  localparam logic [4:0] IF_WAKE     = 5'h03;
  localparam logic [4:0] IF_LFCLK    = 5'h04;

  // Bus handshake states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } eim_bus_state_t;

  // Internal device signals offered to the pins
  typedef struct packed {
    logic por;
    logic wakeup_timer_expired;
    logic low_battery;
    logic tx_data_clk;
    logic tx_state_cmd;
    logic fifo_almost_empty;
    logic fifo_almost_full;
    logic rx_data;
    logic rx_clk;
    logic in_rx;
    logic in_sleep;
    logic in_standby;
    logic in_ready;
    logic in_lock;
    logic antenna_sw;
    logic preamble_flag;
    logic sync_flag;
    logic rssi_above;
    logic txrx_ind;
    logic smps_en;
    logic wait_lock;
    logic onoff_smooth_tx_data;
    logic wait_osc_second_ready;
    logic wait_settle;
    logic wait_cal;
    logic synth_full_en;
  } eim_src_t;

  // Functions taken in from input pins
  typedef struct packed {
    logic tx_cmd;
    logic rx_cmd;
    logic tx_direct_data;
    logic ext_wakeup;
    logic ext_lf_clk;
  } eim_pin_fn_t;

endpackage

/* File: verilog/eim_top.sv */
// Summary of operation
// - Interrupt request goes out on any pin configured for it.
// - Flag bits 0-6: rx ready, discarded, tx sent, max retx, crc, fifo errs.
// - Flag bits 7-11: fifo almost full/empty flags and max back-off.
// - Flag bits 12-14: preamble, sync word, signal above carrier threshold.
// - Flag bits 15-19: wake-up timeout, ready, standby, low battery, reset.
// - Wake-up flag sets only once the crystal oscillator clock is ready.
// - Raw wake-up timer expiry can be driven on a pin.
// - Ready flag sets on each ready entry after oscillator settled.
// - Reading the flag register clears the flag bits that the read returned.
// - A flag stays high for each event that raised an interrupt.
// - Each event has an enable bit; zero blocks its interrupt.
// - Output code 0 drives the active-low interrupt request.
// - Codes 1-3: reset inverted, wake-up expired, low battery.
// - Code 4 drives the internal transmit data clock.
// - Codes 6-9: fifo almost empty/full, rx data, recovered clock.
// - Codes 10,11,12,22,23,24 show receive, awake, standby, sleep, ready, lock.
// - Codes 14-16: preamble flag, sync flag, signal above threshold.
// - Code 19 drives constant high, code 20 constant low.
// - Code 13 antenna switch, 18 tx/rx indicator, 21 regulator enable.
// - Codes 25-30 show internal waits, smooth on/off tx data and synth full enable; 17 and 31 reserved.
// - Input codes 0/1 issue tx/rx commands; code 2 takes tx data.
// - Input code 3 external wake-up, 4 slow clock; 5-31 ignored.
// - Pin configuration holds a five-bit function code in bits 7:3.
// - Direction field: 01 input, 10 low-power out, 11 high-power out.
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps

module eim_top
  import eim_pkg::*;
#(
  parameter int PIN_COUNT = 4
)
(
  // Clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 srst_in,
  // Wishbone slave
  input  wire logic                 wb_cyc_in,
  input  wire logic                 wb_stb_in,
  input  wire logic                 wb_we_in,
  input  wire logic [ADR_W-1:0]     wb_adr_in,
  input  wire logic [3:0]           wb_sel_in,
  input  wire logic [31:0]          wb_dat_in,
  output logic      [31:0]          wb_dat_out,
  output logic                      wb_ack_out,
  // Event sources
  input  wire logic [EVT_W-1:0]     event_pulse_in,
  input  wire logic                 wakeup_timer_end_in,
  input  wire logic                 crystal_osc_ready_in,
  input  wire eim_src_t             src_in,
  // Pins
  input  wire logic [PIN_COUNT-1:0] pin_in,
  output logic      [PIN_COUNT-1:0] pin_out,
  output logic      [PIN_COUNT-1:0] pin_oe_n_out,
  output logic      [PIN_COUNT-1:0] pin_high_power_out,
  // Interrupt and input functions
  output logic                      irq_out_n,
  output eim_pin_fn_t               pin_fn_out
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (PIN_COUNT < 1 || PIN_COUNT > 4)
  begin : g_bad_pins
    $error("PIN_COUNT must be between 1 and 4");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Bus side
  eim_bus_state_t   bus_reg,    bus_next;
  logic [31:0]      rdat_reg,   rdat_next;

  // Software state
  logic [EVT_W-1:0] mask_reg,   mask_next;
  logic [EVT_W-1:0] flags_reg,  flags_next;
  logic [CFG_W-1:0] cfg_reg  [PIN_COUNT];
  logic [CFG_W-1:0] cfg_next [PIN_COUNT];

  // Event tracking
  logic             wut_pend_reg,  wut_pend_next;
  logic             rdy_seen_reg,  rdy_seen_next;
  logic             irq_n_reg,     irq_n_next;

  // Pin side
  logic [PIN_COUNT-1:0] pout_reg,  pout_next;
  logic [PIN_COUNT-1:0] oe_n_reg,  oe_n_next;
  logic [PIN_COUNT-1:0] hp_reg,    hp_next;
  logic [PIN_COUNT-1:0] pin_prev_reg, pin_prev_next;
  eim_pin_fn_t      fn_reg,     fn_next;

  // Decoded access; writes and flag clears taken only at the edge where ack is high, read data at the request edge
  logic             req;
  logic             done;
  logic             rd_flags_done;
  logic [EVT_W-1:0] set_vec;
  logic             rdy_cond;

  // Byte-lane merge for 32-bit writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  // Codes 5 and 26 pass
  // internal strobes as is

  // Output function multiplexer for one pin
  function automatic logic out_sel(input logic [4:0] code,
                                   input eim_src_t   s,
                                   input logic       irq_n);
    logic v;
    v = 1'b0;
    unique case (code)
      OF_IRQ:     v = irq_n;
      OF_POR_N:   v = ~s.por;
      OF_WUT:     v = s.wakeup_timer_expired;
      OF_LOWBAT:  v = s.low_battery;
      OF_TXCLK:   v = s.tx_data_clk;
      OF_TXSTATE: v = s.tx_state_cmd;
      OF_AEMPTY:  v = s.fifo_almost_empty;
      OF_AFULL:   v = s.fifo_almost_full;
      OF_RXDATA:  v = s.rx_data;
      OF_RXCLK:   v = s.rx_clk;
      OF_INRX:    v = s.in_rx;
      OF_AWAKE:   v = ~(s.in_sleep | s.in_standby);
      OF_STANDBY: v = s.in_standby;
      OF_ANTSW:   v = s.antenna_sw;
      OF_PREAMB:  v = s.preamble_flag;
      OF_SYNC:    v = s.sync_flag;
      OF_RSSI:    v = s.rssi_above;
      OF_TXRX:    v = s.txrx_ind;
      OF_VDD:     v = 1'b1;
      OF_GND:     v = 1'b0;
      OF_SMPS:    v = s.smps_en;
      OF_SLEEP:   v = s.in_sleep;
      OF_READY:   v = s.in_ready;
      OF_LOCK:    v = s.in_lock;
      OF_WLOCK:   v = s.wait_lock;
      OF_ONOFF:   v = s.onoff_smooth_tx_data;
      OF_WOSC2:   v = s.wait_osc_second_ready;
      OF_WSETTLE: v = s.wait_settle;
      OF_WCAL:    v = s.wait_cal;
      OF_SYNTH:   v = s.synth_full_en;
      default:    v = 1'b0;                       // Reserved codes
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  // One wait state always.
  // Read data and the flag
  // clear share one word,
  // so only shown bits clear

  // Ack one cycle after the request; writes land on the ack edge only
  always_comb
  begin
    req  = wb_cyc_in & wb_stb_in;
    done = req & (bus_reg == BUS_ACK);
    rd_flags_done = done & ~wb_we_in & (wb_adr_in == OFS_FLAGS);
    bus_next = BUS_IDLE;
    unique case (bus_reg)
      BUS_IDLE: bus_next = req ? BUS_ACK : BUS_IDLE;
      BUS_ACK:  bus_next = BUS_IDLE;
    endcase
  end

  // Unmapped writes are
  // dropped silently

  // Read data, captured at the request edge, unmapped reads zero
  always_comb
  begin
    rdat_next = rdat_reg;
    if (req && bus_reg == BUS_IDLE)
    begin
      rdat_next = RD_ZERO;
      for (int p = 0; p < PIN_COUNT; p++)
      begin
        if (wb_adr_in == OFS_PIN0 + ADR_W'(4 * p))
          rdat_next = {24'h00_0000, cfg_reg[p] & CFG_RES_MASK};
      end
      if (wb_adr_in == OFS_MASK)
        rdat_next = mask_reg;
      if (wb_adr_in == OFS_FLAGS)
        rdat_next = flags_reg;
      if (wb_adr_in == OFS_PINLVL)
        rdat_next = 32'(pin_in);
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Reserved bit masked on
  // write, so it reads zero

  // Only byte lane 0 carries a pin configuration
  always_comb
  begin
    for (int p = 0; p < PIN_COUNT; p++)
    begin
      cfg_next[p] = cfg_reg[p];
      if (done && wb_we_in && wb_sel_in[0] &&
          wb_adr_in == OFS_PIN0 + ADR_W'(4 * p))
        cfg_next[p] = wb_dat_in[7:0] & CFG_RES_MASK;
    end
    mask_next = mask_reg;
    if (done && wb_we_in && wb_adr_in == OFS_MASK)
      mask_next = merge(mask_reg, wb_dat_in, wb_sel_in) & EVT_IMPL;
  end

  // ----------------------------------------------------------------------
  // Event flags and interrupt request
  // ----------------------------------------------------------------------
  // Timer end may come with
  // the oscillator off; it
  // is kept, not lost

  // Timer expiry held until the oscillator clock can record it
  always_comb
  begin
    wut_pend_next = wut_pend_reg | wakeup_timer_end_in;
    if (wut_pend_next && crystal_osc_ready_in)
      wut_pend_next = 1'b0;
    rdy_cond      = src_in.in_ready & crystal_osc_ready_in;
    rdy_seen_next = rdy_cond;
    set_vec = event_pulse_in & EVT_IMPL;
    set_vec[EVT_WAKEUP] = (wut_pend_reg | wakeup_timer_end_in) &
                          crystal_osc_ready_in;
    set_vec[EVT_READY]  = rdy_cond & ~rdy_seen_reg;
    set_vec = set_vec & mask_reg;
  end

  // Flags outlive a later
  // mask clear; only the
  // request follows the mask

  // Clear only what the read reported; a new event always wins
  always_comb
  begin
    flags_next = flags_reg;
    if (rd_flags_done)
      flags_next = flags_reg & ~rdat_reg;
    flags_next = flags_next | set_vec;
    irq_n_next = ~|(flags_next & mask_reg);
  end

  // ----------------------------------------------------------------------
  // Pin drivers and input functions
  // ----------------------------------------------------------------------
  // Same decode per pin.
  // Limitation: pins with
  // one input code are ORed

  // Pin levels are registered; irq reaches a pin one cycle after irq_out_n
  always_comb
  begin
    fn_next = '0;
    pin_prev_next = pin_in;
    for (int p = 0; p < PIN_COUNT; p++)
    begin
      logic [4:0] code;
      logic [1:0] dir;
      logic       is_in;
      code  = cfg_reg[p][FUNC_HI:FUNC_LO];
      dir   = cfg_reg[p][DIR_HI:DIR_LO];
      is_in = (dir == DIR_INPUT);
      pout_next[p] = out_sel(code, src_in, irq_n_reg);
      oe_n_next[p] = ~((dir == DIR_OUT_LO) | (dir == DIR_OUT_HI));
      hp_next[p]   = (dir == DIR_OUT_HI);
      if (is_in)
      begin
        // Commands fire on the rising pin edge only
        if (code == IF_TXCMD)
          fn_next.tx_cmd = fn_next.tx_cmd | (pin_in[p] & ~pin_prev_reg[p]);
        if (code == IF_RXCMD)
          fn_next.rx_cmd = fn_next.rx_cmd | (pin_in[p] & ~pin_prev_reg[p]);
        if (code == IF_TXDATA)
          fn_next.tx_direct_data = fn_next.tx_direct_data | pin_in[p];
        if (code == IF_WAKE)
          fn_next.ext_wakeup = fn_next.ext_wakeup | pin_in[p];
        if (code == IF_LFCLK)
          fn_next.ext_lf_clk = fn_next.ext_lf_clk | pin_in[p];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Synchronous reset only.
  // Reset wins over access.
  // Pins float one cycle,
  // then follow the config.

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      bus_reg      <= BUS_IDLE;
      rdat_reg     <= RD_ZERO;
      mask_reg     <= MASK_RST;
      flags_reg    <= '0;
      wut_pend_reg <= 1'b0;
      rdy_seen_reg <= 1'b0;
      irq_n_reg    <= 1'b1;
      pout_reg     <= '0;
      oe_n_reg     <= '1;
      hp_reg       <= '0;
      pin_prev_reg <= '0;
      fn_reg       <= '0;
      for (int p = 0; p < PIN_COUNT; p++)
        cfg_reg[p] <= (p == 0) ? CFG_RST_PIN0 : CFG_RST_PINX;
    end
    else
    begin
      bus_reg      <= bus_next;
      rdat_reg     <= rdat_next;
      mask_reg     <= mask_next;
      flags_reg    <= flags_next;
      wut_pend_reg <= wut_pend_next;
      rdy_seen_reg <= rdy_seen_next;
      irq_n_reg    <= irq_n_next;
      pout_reg     <= pout_next;
      oe_n_reg     <= oe_n_next;
      hp_reg       <= hp_next;
      pin_prev_reg <= pin_prev_next;
      fn_reg       <= fn_next;
      for (int p = 0; p < PIN_COUNT; p++)
        cfg_reg[p] <= cfg_next[p];
    end
  end

  // No gate between these
  // flops and the pins

  // Outputs straight from flip-flops
  assign wb_ack_out         = (bus_reg == BUS_ACK);
  assign wb_dat_out         = rdat_reg;
  assign irq_out_n          = irq_n_reg;
  assign pin_out            = pout_reg;
  assign pin_oe_n_out       = oe_n_reg;
  assign pin_high_power_out = hp_reg;
  assign pin_fn_out         = fn_reg;

endmodule

/* File: test/eim_checker.sv */
`timescale 1ns/100ps

module eim_checker
  import eim_pkg::*;
#(
  parameter int PIN_COUNT = 4
)
(
  // Clock and reset
  input wire logic                 clock_in,
  input wire logic                 srst_in,
  // Register bus
  input wire logic                 wb_cyc_in,
  input wire logic                 wb_stb_in,
  input wire logic [31:0]          wb_dat_out,
  input wire logic                 wb_ack_out,
  // Events and pins
  input wire logic [EVT_W-1:0]     event_pulse_in,
  input wire logic                 crystal_osc_ready_in,
  input wire logic [PIN_COUNT-1:0] pin_in,
  input wire logic [PIN_COUNT-1:0] pin_oe_n_out,
  input wire logic [PIN_COUNT-1:0] pin_high_power_out,
  input wire logic                 irq_out_n,
  input wire eim_pin_fn_t          pin_fn_out
);
  logic any_src;
  logic pin_any;
  logic fn_level;

  // Causes that an interrupt or an input level can be traced to
  assign any_src = (|event_pulse_in) | crystal_osc_ready_in;
  assign pin_any = |pin_in;
  assign fn_level = pin_fn_out.tx_direct_data | pin_fn_out.ext_wakeup
                  | pin_fn_out.ext_lf_clk;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_ack_pulse;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_answer;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("ack missing after request");
  property p_dat_hold;
    !(wb_cyc_in && wb_stb_in) |=> $stable(wb_dat_out);
  endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data changed while idle");
  // A second reset may release the request without a read
  property p_irq_release;
    $rose(irq_out_n) |-> $past(wb_ack_out) || $past(srst_in);
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("interrupt released without a read");
  property p_irq_cause;
    $fell(irq_out_n) |-> $past(any_src);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt raised without a cause");
  property p_cmd_pulse;
    pin_fn_out.tx_cmd || pin_fn_out.rx_cmd
      |=> !pin_fn_out.tx_cmd && !pin_fn_out.rx_cmd;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command pulse too long");
  property p_fn_level;
    fn_level |-> $past(pin_any) || $past(pin_any, 2);
  endproperty
  a_fn_level: assert property (p_fn_level)
    else $error("input function high with pins low");
  property p_drive_power;
    (pin_high_power_out & pin_oe_n_out) == '0;
  endproperty
  a_drive_power: assert property (p_drive_power)
    else $error("high power on an undriven pin");

  // Main scenarios reached
  c_irq: cover property ($fell(irq_out_n));
  c_clear: cover property ($rose(irq_out_n));
  c_cmd: cover property (pin_fn_out.tx_cmd);
endmodule

/* File: test/eim_host_model.sv */
`timescale 1ns/100ps

module eim_host_model
  import eim_pkg::*;
(
  // Clock
  input  wire logic       clock_in,
  // Device side of the pins
  input  wire logic [3:0] dev_level_in,
  input  wire logic [3:0] dev_oe_n_in,
  // Host side of the pins
  input  wire logic [3:0] host_level_in,
  input  wire logic [3:0] host_en_in,
  // Resolved wire levels
  output logic      [3:0] wire_level_out
);
  logic [3:0] last_reg;

  // Undriven pins have no pull: show the inverse of the last level
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!dev_oe_n_in[i])
        wire_level_out[i] = dev_level_in[i];
      else if (host_en_in[i])
        wire_level_out[i] = host_level_in[i];
      else
        wire_level_out[i] = ~last_reg[i];
    end
  end

  // Last level seen on each wire
  always_ff @(posedge clock_in)
    last_reg <= wire_level_out;
endmodule

/* File: test/eim_top_bench.sv */
`timescale 1ns/100ps

module eim_top_bench
  import eim_pkg::*;
;
  localparam int PIN_COUNT = 4;
  // Source bit per output code; negatives are irq, high, low, ~por, awake
  localparam int OMAP [32] = '{-1, -4, 24, 23, 22, 21, 20, 19, 18, 17, 16,
    -5, 14, 11, 10, 9, 8, -3, 7, -2, -3, 6, 15, 13, 12, 5, 4, 3, 2, 1, 0, -3};
  logic        clock_in, srst_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [7:0]  wb_adr_in;
  logic [3:0]  wb_sel_in, pin_in, pin_out, pin_oe_n_out, pin_high_power_out;
  logic [3:0]  host_level, host_en;
  logic [31:0] wb_dat_in, wb_dat_out, event_pulse_in, rd;
  logic        wb_ack_out, wakeup_timer_end_in, crystal_osc_ready_in;
  logic        irq_out_n, e;
  logic [4:0]  seen;
  eim_src_t    src_in;
  eim_pin_fn_t pin_fn_out;
  eim_src_t    pats [3] = '{26'h0, 26'h2aaaaaa, 26'h1555555};
  int          error_cnt, checks_done, cycle_cnt;

  eim_top #(.PIN_COUNT(PIN_COUNT)) eim_top_inst
  (
    .clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .event_pulse_in(event_pulse_in),
    .wakeup_timer_end_in(wakeup_timer_end_in),
    .crystal_osc_ready_in(crystal_osc_ready_in), .src_in(src_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out),
    .pin_high_power_out(pin_high_power_out), .irq_out_n(irq_out_n),
    .pin_fn_out(pin_fn_out)
  );

  eim_host_model eim_host_model_inst
  (
    .clock_in(clock_in), .dev_level_in(pin_out), .dev_oe_n_in(pin_oe_n_out),
    .host_level_in(host_level), .host_en_in(host_en),
    .wire_level_out(pin_in)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic exp_pin(input int idx, input logic [25:0] s);
    case (idx)
      -1, -2: return 1'b1;
      -3: return 1'b0;
      -4: return ~s[25];
      -5: return ~(s[15] | s[14]);
      default: return s[idx];
    endcase
  endfunction

  task automatic chk(input string what, input logic [31:0] seen_v, exp_v);
    checks_done++;
    if (seen_v !== exp_v)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask

  // Classic cycle: hold the request until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [31:0] wd);
    @(posedge clock_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_dat_in <= wd;
    do
      @(posedge clock_in);
    while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask

  task automatic rdc(input string what, input logic [7:0] adr,
                     input logic [31:0] exp_v);
    bus(1'b0, adr, 32'h0);
    chk(what, rd, exp_v);
  endtask

  task automatic pulse(input logic [31:0] ev);
    @(posedge clock_in);
    event_pulse_in <= ev;
    @(posedge clock_in);
    event_pulse_in <= 32'h0;
    repeat (2) @(posedge clock_in);
  endtask

  task automatic end_of_test();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Clock and hang guard
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cycle_cnt++;
    if (cycle_cnt == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {srst_in, wb_sel_in, crystal_osc_ready_in} = 6'h3f;
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} = '0;
    {event_pulse_in, wakeup_timer_end_in, src_in} = '0;
    {host_level, host_en} = 8'h0;
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    rdc("pin0 cfg", OFS_PIN0, 32'h0a);
    rdc("pin2 cfg", OFS_PIN0 + 8'h08, 32'ha2);
    rdc("mask", OFS_MASK, 32'h0);
    rdc("unmapped", 8'h1c, 32'h0);
    chk("pin0 por", pin_out[0], 1'b1);
    chk("pins gnd", pin_out[3:1], 3'h0);
    chk("pins oe", pin_oe_n_out, 4'h0);
    bus(1'b1, OFS_PIN0 + 8'h0c, 32'hff);
    rdc("pin3 rsvd", OFS_PIN0 + 8'h0c, 32'hfb);
    // Every output code against three source patterns
    for (int c = 0; c < 32; c++)
    begin
      bus(1'b1, OFS_PIN0 + 8'h04, {24'h0, 5'(c), 3'b011});
      for (int p = 0; p < 3; p++)
      begin
        src_in <= pats[p];
        repeat (3) @(posedge clock_in);
        e = exp_pin(OMAP[c], pats[p]);
        if (c < 16)
          chk("out lo", pin_out[1], e);
        else
          chk("out hi", pin_out[1], e);
      end
    end
    chk("pin1 hp", {pin_high_power_out[1], pin_oe_n_out[1]}, 2'b10);
    src_in <= '0;
    // Masked and enabled events, pin 0 carries the request
    bus(1'b1, OFS_PIN0, 32'h02);
    bus(1'b1, OFS_MASK, 32'h04);
    pulse(32'h08);
    chk("irq masked", irq_out_n, 1'b1);
    rdc("flags masked", OFS_FLAGS, 32'h0);
    pulse(32'h04);
    chk("irq", irq_out_n, 1'b0);
    chk("pin0 irq", pin_out[0], 1'b0);
    rdc("flags", OFS_FLAGS, 32'h04);
    @(posedge clock_in);
    chk("irq clear", irq_out_n, 1'b1);
    rdc("flags clr", OFS_FLAGS, 32'h0);
    bus(1'b1, OFS_MASK, 32'hffffffff);
    for (int b = 0; b < 32; b++)
      if (EVT_IMPL[b] && b != EVT_WAKEUP && b != EVT_READY)
      begin
        pulse(32'h1 << b);
        rdc("flag bit", OFS_FLAGS, 32'h1 << b);
      end
    // Wake-up waits for the oscillator
    crystal_osc_ready_in <= 1'b0;
    @(posedge clock_in);
    wakeup_timer_end_in <= 1'b1;
    @(posedge clock_in);
    wakeup_timer_end_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    chk("wake early", irq_out_n, 1'b1);
    crystal_osc_ready_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    chk("wake irq", irq_out_n, 1'b0);
    rdc("wake flag", OFS_FLAGS, 32'h1 << EVT_WAKEUP);
    repeat (2)
    begin
      src_in.in_ready <= 1'b1;
      repeat (3) @(posedge clock_in);
      rdc("ready flag", OFS_FLAGS, 32'h1 << EVT_READY);
      src_in.in_ready <= 1'b0;
      @(posedge clock_in);
    end
    // Input codes on pin 2, host raises the wire after three low cycles
    host_en <= 4'b0100;
    for (int c = 0; c < 6; c++)
    begin
      host_level <= 4'h0;
      bus(1'b1, OFS_PIN0 + 8'h08, {24'h0, 5'(c), 3'b001});
      repeat (3) @(posedge clock_in);
      host_level <= 4'h4;
      seen = '0;
      repeat (4)
      begin
        @(posedge clock_in);
        seen = seen | pin_fn_out;
      end
      chk("in fn", seen, (c < 5) ? (5'h10 >> c) : 5'h0);
      chk("in oe", pin_oe_n_out[2], 1'b1);
    end
    end_of_test();
  end
endmodule

bind eim_top eim_checker #(.PIN_COUNT(PIN_COUNT)) eim_checker_inst
(
  .clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .event_pulse_in(event_pulse_in),
  .crystal_osc_ready_in(crystal_osc_ready_in), .pin_in(pin_in),
  .pin_oe_n_out(pin_oe_n_out), .pin_high_power_out(pin_high_power_out),
  .irq_out_n(irq_out_n), .pin_fn_out(pin_fn_out)
);
